// ===== hdl/mcd_core.sv
// Purpose: decode and control of a single-cycle transfer-triggered core
// Assumes: instruction word for pc arrives in the same cycle it is fetched
// Notes:   external source modules decode the source field from instr themselves
// What this block does
// [RULE1] Fetch and execute one instruction per cycle
// [RULE2] Every instruction is one sixteen-bit move
// [RULE3] Top bit chooses how source field is read
// [RULE4] Low byte is immediate or source register
// [RULE5] Source nibbles give module and register index
// [RULE6] Bits eight to fourteen pick destination register
// [RULE7] Upper destination indices need a prefix write first
// [RULE8] Certain register transfers trigger side effects
// [RULE9] Arithmetic, logic and jumps are register moves
// [RULE10] Data pointers step after each access optionally
// [RULE11] Sixteen-entry stack for calls, interrupts, push, pop
// [RULE12] Reset loads stack pointer with fifteen
// [RULE13] Push: increment pointer, then write entry
// [RULE14] Pop: read entry, then decrement pointer
// [RULE15] EEPROM execution maps SRAM and ROM as data
// [RULE16] SRAM execution maps EEPROM and ROM as data
// [RULE17] ROM execution maps EEPROM and SRAM as data
// [RULE18] Executing segment never reachable as data
// [RULE19] Program EEPROM 8K words, data SRAM 512
// [RULE20] Utility ROM 2K words starting at 8000h
// [RULE21] After reset fetching starts in utility ROM
// [RULE22] Programming and debug locked until password matches
// [RULE23] Stack pointer four bits, wraps silently
// [RULE24] Prefix value lasts only one instruction
`timescale 1ns/100ps
`default_nettype none
module mcd_core
    import mcd_pkg::*;
(
    input  wire logic        core_clk,      // 200 MHz core clock
    input  wire logic        rst_n,         // async reset, active low
    input  wire logic [15:0] instr,         // instruction word at pc
    input  wire logic        instr_valid,   // instruction word present
    input  wire logic [15:0] ext_src_data,  // value of an external source register
    input  wire logic [15:0] data_rdata,    // data word at data_addr
    input  wire logic        int_req,       // pending interrupt, level
    input  wire logic [15:0] int_vector,    // interrupt service address
    input  wire logic        pw_lock_en,    // password lock enabled
    input  wire logic        key_valid,     // key word strobe from debug port
    input  wire logic [15:0] key_word,      // key word offered
    input  wire logic [15:0] pw_ref_word,   // stored key word at pw_index
    input  wire logic        key_relock,    // drop granted access
    output logic      [15:0] pc,            // program fetch address
    output logic      [1:0]  exec_seg,      // segment being executed from
    output logic      [3:0]  stack_pointer, // stack pointer
    output logic      [15:0] acc,           // accumulator
    output logic             carry,         // carry flag
    output logic             int_en,        // interrupt global enable
    output logic             int_ack,       // vectoring cycle, pulse
    output logic             prefix_active, // prefix applies to next word
    output logic      [15:0] data_addr,     // data read address
    output logic      [2:0]  data_sel,      // data read memory select
    output logic             data_wr,       // data write strobe, pulse
    output logic      [15:0] data_wr_addr,  // data write address
    output logic      [2:0]  data_wr_sel,   // data write memory select
    output logic      [15:0] data_wdata,    // data write value
    output logic             data_fault,    // access to unmapped data, pulse
    output logic             ext_wr,        // external register write, pulse
    output logic      [3:0]  ext_wr_mod,    // external destination module
    output logic      [4:0]  ext_wr_idx,    // external destination index
    output logic      [15:0] ext_wr_data,   // external write value
    output logic      [3:0]  pw_index,      // key word position expected
    output logic             util_access    // programming and debug allowed
);
    logic        rst_ff1;
    logic        rst_sync_n;
    logic [15:0] prefix_register;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [2:0]  dp_ctrl;
    mcd_pw_t     pw_state;
    wire  [15:0] stk_top;
    wire  [3:0]  stk_sp;

    function automatic logic hit(input logic [3:0] m, input logic [4:0] i,
                                 input logic [3:0] cm, input logic [4:0] ci);
        return (m == cm) && (i == ci);
    endfunction

    function automatic logic in_win(input logic [15:0] a, input logic [15:0] base,
                                    input logic [15:0] words);
        return (a >= base) && (a < (base + words));
    endfunction

    // data windows open only for segments not executing
    function automatic logic [2:0] map_sel(input logic [15:0] a, input mcd_seg_t s);
        logic [2:0] r;
        r = 3'h0;
        r[SEL_SRAM] = in_win(a, D_SRAM_BASE, SRAM_WORDS) && (s != SEG_SRAM);
        r[SEL_EE]   = in_win(a, D_EE_BASE, EE_WORDS) && (s != SEG_EE);
        r[SEL_ROM]  = in_win(a, D_ROM_BASE, ROM_WORDS) && (s != SEG_ROM);
        return r;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff1    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_ff1    <= 1'b1;
            rst_sync_n <= rst_ff1;
        end
    end

    // instruction fields
    wire        fmt_reg  = instr[FMT_BIT]; // [RULE3]

    // source field
    wire [7:0]  src_byte = instr[7:0]; // [RULE4]
    wire [3:0]  src_mod  = instr[SRC_MOD_LSB +: 4]; // [RULE5]
    wire [4:0]  src_idx  = {1'b0, instr[SRC_IDX_LSB +: 4]}; // [RULE5]

    // destination field
    wire [3:0]  dst_mod  = instr[DST_MOD_LSB +: 4]; // [RULE6]
    wire [1:0]  dst_ext  = prefix_active ? prefix_register[PFX_EXT_LSB +: 2] : 2'b00;
    wire [4:0]  dst_idx  = {dst_ext, instr[DST_IDX_LSB +: 3]}; // [RULE7]

    // vectoring replaces the fetched word, never splits a prefix pair
    wire take_int = instr_valid && int_req && int_en && !prefix_active;
    wire exec     = instr_valid && !take_int; // [RULE1]

    // source decode
    wire s_acc  = fmt_reg && hit(src_mod, src_idx, MOD_ACC, IDX_ACC);
    wire s_pfx  = fmt_reg && hit(src_mod, src_idx, MOD_PFX, IDX_PFX);
    wire s_ip   = fmt_reg && hit(src_mod, src_idx, MOD_IP, IDX_IP);
    wire s_sp   = fmt_reg && hit(src_mod, src_idx, MOD_STK, IDX_SP);
    wire s_pop  = fmt_reg && hit(src_mod, src_idx, MOD_STK, IDX_STACK);
    wire s_pop_and_restore_interrupts = fmt_reg && hit(src_mod, src_idx, MOD_STK, IDX_POP_AND_RESTORE_INTERRUPTS);

    wire s_dp0  = fmt_reg && hit(src_mod, src_idx, MOD_DP, IDX_DP0);
    wire s_dp1  = fmt_reg && hit(src_mod, src_idx, MOD_DP, IDX_DP1);
    wire s_dpc  = fmt_reg && hit(src_mod, src_idx, MOD_DPC, IDX_DPCTL);
    wire s_mem  = fmt_reg && hit(src_mod, src_idx, MOD_DP, IDX_MEM);

    wire [15:0] src_val =
        !fmt_reg        ? {8'h00, src_byte} : // [RULE4]
        s_acc           ? acc :
        s_pfx           ? prefix_register :
        s_ip            ? pc :
        s_sp            ? {12'h000, stk_sp} :
        (s_pop|s_pop_and_restore_interrupts)  ? stk_top :
        s_dp0           ? dp0 :
        s_dp1           ? dp1 :
        s_dpc           ? {13'h0000, dp_ctrl} :
        s_mem           ? data_rdata :
                          ext_src_data; // [RULE5]

    // destination decode, every write location with a side effect
    wire d_acc  = hit(dst_mod, dst_idx, MOD_ACC, IDX_ACC);
    wire d_addc = hit(dst_mod, dst_idx, MOD_ALU, IDX_ADDC);
    wire d_or   = hit(dst_mod, dst_idx, MOD_ALU, IDX_OR);
    wire d_and  = hit(dst_mod, dst_idx, MOD_ALU, IDX_AND);
    wire d_xor  = hit(dst_mod, dst_idx, MOD_ALU, IDX_XOR);
    wire d_pfx  = hit(dst_mod, dst_idx, MOD_PFX, IDX_PFX);
    wire d_ip   = hit(dst_mod, dst_idx, MOD_IP, IDX_IP);
    wire d_call = hit(dst_mod, dst_idx, MOD_IP, IDX_CALL);
    wire d_push = hit(dst_mod, dst_idx, MOD_STK, IDX_STACK);
    wire d_dp0  = hit(dst_mod, dst_idx, MOD_DP, IDX_DP0);
    wire d_dp1  = hit(dst_mod, dst_idx, MOD_DP, IDX_DP1);
    wire d_dpc  = hit(dst_mod, dst_idx, MOD_DPC, IDX_DPCTL);
    wire d_mem  = hit(dst_mod, dst_idx, MOD_DP, IDX_MEM);
    wire d_ie   = hit(dst_mod, dst_idx, MOD_CTL, IDX_IE);

    wire d_alu  = d_addc | d_or | d_and | d_xor;
    wire d_own  = d_acc | d_alu | d_pfx | d_ip | d_call | d_push | d_dp0 | d_dp1
                | d_dpc | d_mem | d_ie;

    // accumulator operations as moves into the operator locations
    wire [16:0] sum     = {1'b0, acc} + {1'b0, src_val} + {16'h0000, carry};

    wire [15:0] alu_res = d_addc ? sum[15:0] :
                          d_or   ? (acc | src_val) :
                          d_and  ? (acc & src_val) :
                                   (acc ^ src_val); // [RULE9]

    wire [15:0] next_acc   = (exec && d_acc) ? src_val :
                             (exec && d_alu) ? alu_res : acc; // [RULE8]

    wire        next_carry = (exec && d_addc) ? sum[16] : carry; // [RULE9]

    // program flow: jump, call, return all via the ip locations
    wire [15:0] pc_seq  = pc + 16'h0001;

    wire [15:0] next_pc = take_int               ? int_vector :
                          !instr_valid           ? pc :
                          (d_ip || d_call)       ? src_val : pc_seq; // [RULE9]

    wire        stk_push  = take_int || (exec && (d_push || d_call)); // [RULE11]

    wire        stk_pop   = exec && (s_pop || s_pop_and_restore_interrupts); // [RULE14]
    wire [15:0] stk_wdata = take_int ? pc : d_call ? pc_seq : src_val; // [RULE13]

    wire        next_int_en = take_int            ? 1'b0 :
                              (exec && s_pop_and_restore_interrupts)    ? 1'b1 :
                              (exec && d_ie)      ? src_val[IE_BIT] : int_en;

    // prefix lives for exactly one following instruction
    wire        next_pfx_live = exec ? d_pfx : prefix_active; // [RULE24]

    wire [15:0] next_pfx      = (exec && d_pfx) ? src_val :
                                exec            ? 16'h0000 : prefix_register; // [RULE24]

    // data pointers with optional post step
    wire        dp_use1  = dp_ctrl[DPC_SEL_BIT];
    wire [15:0] act_dp   = dp_use1 ? dp1 : dp0;
    wire        mem_acc  = exec && (s_mem || d_mem);
    wire        do_step  = mem_acc && dp_ctrl[DPC_STEP_BIT];
    wire [15:0] stepped  = dp_ctrl[DPC_DEC_BIT] ? (act_dp - 16'h0001) : (act_dp + 16'h0001);

    wire [15:0] next_dp0 = (exec && d_dp0)       ? src_val :
                           (do_step && !dp_use1) ? stepped : dp0; // [RULE10]

    wire [15:0] next_dp1 = (exec && d_dp1)       ? src_val :
                           (do_step && dp_use1)  ? stepped : dp1; // [RULE10]

    wire [2:0]  next_dpc = (exec && d_dpc) ? src_val[2:0] : dp_ctrl;
    wire [15:0] next_addr = next_dpc[DPC_SEL_BIT] ? next_dp1 : next_dp0;

    // which segment the next fetch comes from
    wire rom_pc  = in_win(next_pc, ROM_PC_BASE, ROM_WORDS); // [RULE20]

    wire sram_pc = in_win(next_pc, SRAM_PC_BASE, SRAM_WORDS); // [RULE19]

    wire [1:0] next_seg = rom_pc  ? SEG_ROM :
                          sram_pc ? SEG_SRAM : SEG_EE;
    wire [2:0] next_sel = map_sel(next_addr, mcd_seg_t'(next_seg));           // [RULE18]

    // password sequence
    wire key_ok    = key_valid && (key_word == pw_ref_word);
    wire key_done  = key_ok && (pw_index == PW_LAST);
    wire next_open = (pw_state == PW_OPEN) ? !key_relock : key_done;          // [RULE22]

    mcd_stack u_stack (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .push       (stk_push),
        .pop        (stk_pop),
        .wdata      (stk_wdata),
        .rdata      (stk_top),
        .sp         (stk_sp)
    );

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin

            pc            <= PC_RESET; // [RULE21]
            exec_seg      <= SEG_ROM; // [RULE21]

            acc           <= 16'h0000;
            carry         <= 1'b0;
            int_en        <= 1'b0;
            int_ack       <= 1'b0;
            prefix_active <= 1'b0;
            prefix_register <= 16'h0000;
        end else begin

            pc            <= next_pc; // [RULE1]

            exec_seg      <= next_seg;
            acc           <= next_acc;
            carry         <= next_carry;
            int_en        <= next_int_en;
            int_ack       <= take_int;
            prefix_active <= next_pfx_live; // [RULE7]

            prefix_register <= next_pfx;
        end
    end

    // the stack's own pointer register drives the port directly
    assign stack_pointer = stk_sp; // [RULE12]

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dp0       <= 16'h0000;
            dp1       <= 16'h0000;
            dp_ctrl   <= 3'h0;
            data_addr <= 16'h0000;
            data_sel  <= 3'h0;
        end else begin
            dp0       <= next_dp0;
            dp1       <= next_dp1;
            dp_ctrl   <= next_dpc;

            data_addr <= next_addr;
            data_sel  <= next_sel; // [RULE15]
        end
    end

    // data-space writes go through the active pointer's current mapping
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            data_wr      <= 1'b0;
            data_wr_addr <= 16'h0000;
            data_wr_sel  <= 3'h0;
            data_wdata   <= 16'h0000;
            data_fault   <= 1'b0;
        end else begin
            data_wr      <= exec && d_mem && (data_sel != 3'h0); // [RULE16]

            data_wr_addr <= act_dp;

            data_wr_sel  <= data_sel; // [RULE17]
            data_wdata   <= src_val;

            data_fault   <= mem_acc && (data_sel == 3'h0); // [RULE18]
        end
    end

    // moves into registers outside the core
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_wr      <= 1'b0;
            ext_wr_mod  <= 4'h0;
            ext_wr_idx  <= 5'h00;
            ext_wr_data <= 16'h0000;
        end else begin
            ext_wr      <= exec && !d_own; // [RULE2]

            ext_wr_mod  <= dst_mod; // [RULE6]
            ext_wr_idx  <= dst_idx; // [RULE7]

            ext_wr_data <= src_val;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pw_state    <= PW_LOCKED;
            pw_index    <= 4'h0;
            util_access <= 1'b0;
        end else begin
            pw_state    <= next_open ? PW_OPEN : PW_LOCKED; // [RULE22]

            pw_index    <= (!key_valid || next_open) ? (next_open ? 4'h0 : pw_index) :
                           key_ok ? pw_index + 4'h1 : 4'h0;
            util_access <= !pw_lock_en || next_open; // [RULE22]
        end
    end
endmodule : mcd_core
`default_nettype wire

// ===== hdl/mcd_pkg.sv
// Purpose: shared constants and types for the move-core control block
// Assumes: one 200 MHz core clock, one instruction word per cycle
// Notes:   module codes, index codes and address windows used by core and stack
package mcd_pkg;

    // instruction word fields and prefix extension field
    localparam int          FMT_BIT      = 15;
    localparam int          SRC_MOD_LSB  = 0;
    localparam int          SRC_IDX_LSB  = 4;
    localparam int          DST_MOD_LSB  = 8;
    localparam int          DST_IDX_LSB  = 12;
    localparam int          PFX_EXT_LSB  = 0;

    // module specifiers
    localparam logic [3:0]  MOD_CTL      = 4'h8;
    localparam logic [3:0]  MOD_ACC      = 4'h9;
    localparam logic [3:0]  MOD_ALU      = 4'ha;
    localparam logic [3:0]  MOD_PFX      = 4'hb;
    localparam logic [3:0]  MOD_IP       = 4'hc;
    localparam logic [3:0]  MOD_STK      = 4'hd;
    localparam logic [3:0]  MOD_DPC      = 4'he;
    localparam logic [3:0]  MOD_DP       = 4'hf;

    // register indices inside those modules
    localparam logic [4:0]  IDX_IE       = 5'h05;
    localparam logic [4:0]  IDX_ACC      = 5'h00;
    localparam logic [4:0]  IDX_ADDC     = 5'h00;
    localparam logic [4:0]  IDX_OR       = 5'h01;
    localparam logic [4:0]  IDX_AND      = 5'h02;
    localparam logic [4:0]  IDX_XOR      = 5'h03;
    localparam logic [4:0]  IDX_PFX      = 5'h00;
    localparam logic [4:0]  IDX_IP       = 5'h00;
    localparam logic [4:0]  IDX_CALL     = 5'h01;
    localparam logic [4:0]  IDX_STACK    = 5'h00;
    localparam logic [4:0]  IDX_SP       = 5'h01;
    localparam logic [4:0]  IDX_POP_AND_RESTORE_INTERRUPTS     = 5'h03;
    localparam logic [4:0]  IDX_DPCTL    = 5'h04;
    localparam logic [4:0]  IDX_MEM      = 5'h00;
    localparam logic [4:0]  IDX_DP0      = 5'h03;
    localparam logic [4:0]  IDX_DP1      = 5'h07;

    // data pointer control bits and interrupt enable bit
    localparam int          DPC_SEL_BIT  = 0;
    localparam int          DPC_STEP_BIT = 1;
    localparam int          DPC_DEC_BIT  = 2;
    localparam int          IE_BIT       = 0;

    // program space
    localparam logic [15:0] EE_PC_BASE   = 16'h0000;
    localparam logic [15:0] EE_WORDS     = 16'h2000;
    localparam logic [15:0] ROM_PC_BASE  = 16'h8000;
    localparam logic [15:0] ROM_WORDS    = 16'h0800;
    localparam logic [15:0] SRAM_PC_BASE = 16'ha000;
    localparam logic [15:0] SRAM_WORDS   = 16'h0200;
    localparam logic [15:0] PC_RESET     = 16'h8000;

    // data space windows
    localparam logic [15:0] D_SRAM_BASE  = 16'h0000;
    localparam logic [15:0] D_EE_BASE    = 16'h4000;
    localparam logic [15:0] D_ROM_BASE   = 16'h8000;

    // stack
    localparam int          STK_DEPTH    = 16;
    localparam logic [3:0]  SP_RESET     = 4'hf;
    localparam logic [3:0]  SP_STEP      = 4'h1;

    // password key length
    localparam logic [3:0]  PW_LAST      = 4'hf;

    // data select one-hot positions
    localparam int          SEL_SRAM     = 0;
    localparam int          SEL_EE       = 1;
    localparam int          SEL_ROM      = 2;

    typedef enum logic [1:0] {
        SEG_EE   = 2'b00,
        SEG_SRAM = 2'b01,
        SEG_ROM  = 2'b10
    } mcd_seg_t;

    typedef enum logic [0:0] {
        PW_LOCKED = 1'b0,
        PW_OPEN   = 1'b1
    } mcd_pw_t;

endpackage : mcd_pkg

// ===== hdl/mcd_stack.sv
// Purpose: sixteen-entry hardware stack with its own pointer
// Assumes: push and pop are single-cycle strobes from the core
// Notes:   pointer wraps silently; push and pop together replace the top entry
`timescale 1ns/100ps
`default_nettype none
module mcd_stack
    import mcd_pkg::*;
(
    input  wire logic        core_clk,    // core clock
    input  wire logic        rst_sync_n,  // synchronised reset, active low
    input  wire logic        push,        // write a new entry
    input  wire logic        pop,         // drop the top entry
    input  wire logic [15:0] wdata,       // value to push
    output wire logic [15:0] rdata,       // entry at the pointer
    output logic      [3:0]  sp           // stack pointer
);
    logic [15:0] mem [STK_DEPTH];
    logic [3:0]  sp_inc;
    logic [3:0]  wr_slot;

    assign sp_inc  = sp + SP_STEP;
    assign wr_slot = (push && !pop) ? sp_inc : sp; // [RULE13]
    assign rdata   = mem[sp]; // [RULE14]

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sp <= SP_RESET; // [RULE12]
        end else if (push && !pop) begin
            sp <= sp_inc; // [RULE23]
        end else if (pop && !push) begin
            sp <= sp - SP_STEP; // [RULE23]
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_slot] <= wdata; // [RULE11]
        end
    end
endmodule : mcd_stack
`default_nettype wire

// ===== tb/mcd_core_sva.sv
// Purpose: timing checks on decode, stack and map outputs
// Assumes: first word runs at the third edge after rst_n rises
// Notes:   words taken by an interrupt are excluded
`timescale 1ns/100ps
`default_nettype none
module mcd_core_chk
    import mcd_pkg::*;
(
    input wire logic        core_clk,      // clock
    input wire logic        rst_n,         // reset
    input wire logic [15:0] instr,         // word
    input wire logic        instr_valid,   // word present
    input wire logic        int_req,       // irq
    input wire logic        int_en,        // irq enable
    input wire logic [15:0] pc,            // fetch address
    input wire logic [1:0]  exec_seg,      // segment
    input wire logic [3:0]  stack_pointer, // pointer
    input wire logic [15:0] acc,           // accumulator
    input wire logic        prefix_active, // prefix
    input wire logic [2:0]  data_sel       // data select
);
    logic [1:0] up_cnt;
    logic [1:0] exp_seg;
    logic [2:0] own_sel;
    logic       exe;
    logic       plain;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) up_cnt <= 2'h0;
        else if (up_cnt != 2'h2) up_cnt <= up_cnt + 2'h1;
    assign exe     = (up_cnt == 2'h2) && instr_valid && !(int_req && int_en);
    assign plain   = exe && !prefix_active;
    assign exp_seg = (pc[15:11] == 5'h10) ? 2'h2 : (pc[15:9] == 7'h50) ? 2'h1 : 2'h0;
    assign own_sel = (exec_seg == 2'h0) ? 3'h2 : (exec_seg == 2'h1) ? 3'h1 : 3'h4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    push_inc_a: assert property (plain && instr[14:8] == 7'h0d && !instr[15]
        |=> stack_pointer == $past(stack_pointer) + 4'h1) else $error("push step wrong");
    pop_dec_a: assert property (plain && instr[15] && instr[7:0] == 8'h0d
        && instr[14:8] != 7'h0d && instr[14:8] != 7'h1c
        |=> stack_pointer == $past(stack_pointer) - 4'h1) else $error("pop step wrong");
    jump_pc_a: assert property (plain && instr[14:8] == 7'h0c && !instr[15]
        |=> pc == {8'h00, $past(instr[7:0])}) else $error("jump target wrong");
    acc_imm_a: assert property (plain && instr[14:8] == 7'h09 && !instr[15]
        |=> acc == {8'h00, $past(instr[7:0])} && pc == $past(pc) + 16'h1) else $error("move wrong");
    pfx_clear_a: assert property (exe && prefix_active && instr[11:8] != 4'hb
        |=> !prefix_active) else $error("prefix held");
    reset_entry_a: assert property (up_cnt != 2'h2
        |-> pc == PC_RESET && stack_pointer == SP_RESET) else $error("reset entry wrong");
    seg_map_a: assert property (exec_seg == exp_seg) else $error("segment wrong");
    seg_closed_a: assert property ($stable(exec_seg) |-> (data_sel & own_sel) == 3'h0)
        else $error("own segment open as data");
    wrap_c: cover property (plain && instr[14:8] == 7'h0d && stack_pointer == 4'hf);
    sram_c: cover property (exec_seg == 2'h1);
    pfx_c: cover property (exe && prefix_active);
endmodule : mcd_core_chk
bind mcd_core mcd_core_chk mcd_core_chk_inst (.core_clk, .rst_n, .instr, .instr_valid,
    .int_req, .int_en, .pc, .exec_seg, .stack_pointer, .acc, .prefix_active, .data_sel);
`default_nettype wire

// ===== tb/mcd_mem_model.sv
// Purpose: program store and key store facing the core
// Assumes: pc low nibble selects one of sixteen program words
// Notes:   the bench reloads the words before each reset except the key test's
`timescale 1ns/100ps
`default_nettype none
module mcd_mem_model (
    input  wire logic [15:0] prog [16],  // program words
    input  wire logic [15:0] pc,         // fetch address
    input  wire logic [3:0]  pw_index,   // key position
    output logic      [15:0] instr,      // word at pc
    output logic      [15:0] pw_ref_word // stored key word
);
    assign instr       = prog[pc[3:0]];
    assign pw_ref_word = 16'h1000 + {12'h000, pw_index};
endmodule : mcd_mem_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: directed tests of moves, stack, prefix, segments and key unlock
// Assumes: 200 MHz clock, inputs change 1 ns after the rising edge
// Notes:   each test resets the core; all but t_key reload the program store first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import mcd_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        key_valid = 1'b0;
    logic        key_relock = 1'b0;
    logic        pw_lock_en = 1'b1;
    logic [15:0] key_word = 16'h0000;
    logic [15:0] ext_src_data = 16'ha001;
    logic [15:0] prog [16] = '{default: 16'h0c00};
    logic [15:0] instr, pw_ref_word, pc, acc, ext_wr_data;
    logic [4:0]  ext_wr_idx;
    logic [3:0]  stack_pointer, pw_index, ext_wr_mod;
    logic [2:0]  data_sel;
    logic [1:0]  exec_seg;
    logic        prefix_active, ext_wr, util_access;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    always #2.5 core_clk = ~core_clk;
    mcd_mem_model mcd_mem_model_inst (.prog, .pc, .pw_index, .instr, .pw_ref_word);
    mcd_core mcd_core_inst (.core_clk, .rst_n, .instr, .instr_valid(1'b1), .ext_src_data,
        .data_rdata(16'h0000), .int_req(1'b0), .int_vector(16'h0000), .pw_lock_en, .key_valid,
        .key_word, .pw_ref_word, .key_relock, .pc, .exec_seg, .stack_pointer, .acc, .carry(),
        .int_en(), .int_ack(), .prefix_active, .data_addr(), .data_sel, .data_wr(),
        .data_wr_addr(), .data_wr_sel(), .data_wdata(), .data_fault(), .ext_wr, .ext_wr_mod,
        .ext_wr_idx, .ext_wr_data, .pw_index, .util_access);
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic restart();
        rst_n = 1'b0;
        step(10);
        rst_n = 1'b1;
    endtask : restart
    task automatic key(input logic [15:0] w);
        key_word = w;
        key_valid = 1'b1;
        step(1);
        key_valid = 1'b0;
        step(1);
    endtask : key
    task automatic t_flow();
        logic [15:0] pcs [5] = '{16'h8002, 16'h0007, 16'h000a, 16'h0008, 16'h0009};
        logic [3:0]  sps [5] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'hf};
        prog = '{0: 16'h0905, 1: 16'h0d33, 2: 16'h0c07, 7: 16'h1c0a, 8: 16'h890d,
                 9: 16'h0c09, 10: 16'h8c0d, default: 16'h0c00};
        restart();
        check(stack_pointer, SP_RESET);
        step(2);
        check(pc, PC_RESET);
        step(1);
        check(acc, 16'h0005);
        for (int i = 0; i < 5; i++) begin
            step(1);
            check(pc, pcs[i]);
            check(stack_pointer, sps[i]);
        end
        check(acc, 16'h0033);
        check(data_sel, 3'h1);
        $display("flow test done");
    endtask : t_flow
    task automatic t_prefix();
        prog = '{0: 16'h0b01, 1: 16'h0955, 2: 16'h0977, default: 16'h0c03};
        restart();
        step(3);
        check(prefix_active, 1'b1);
        step(1);
        check({ext_wr, ext_wr_mod, ext_wr_idx}, 10'h328);
        check(ext_wr_data, 16'h0055);
        step(1);
        check({ext_wr, prefix_active, acc}, 18'h00077);
        $display("prefix test done");
    endtask : t_prefix
    task automatic t_seg();
        prog = '{0: 16'h0c01, 1: 16'h8c00, default: 16'h0c00};
        restart();
        step(3);
        check(exec_seg, 2'h0);
        step(1);
        check(pc, 16'ha001);
        check(exec_seg, 2'h1);
        step(2);
        check(data_sel, 3'h0);
        $display("segment test done");
    endtask : t_seg
    task automatic t_key();
        restart();
        step(3);
        for (int i = 0; i < 3; i++) key(16'h1000 + 16'(i));
        key(16'h0bad);
        check(pw_index, 4'h0);
        for (int i = 0; i < 16; i++) begin
            check(util_access, 1'b0);
            key(16'h1000 + 16'(i));
        end
        check(util_access, 1'b1);
        key_relock = 1'b1;
        step(1);
        key_relock = 1'b0;
        step(1);
        check(util_access, 1'b0);
        $display("key test done");
    endtask : t_key
    initial begin
        t_flow();
        t_prefix();
        t_seg();
        t_key();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
